// ---- bsc_regs.svh ----
// Register offsets, fields, reset values and error codes of the send command block
`ifndef BSC_REGS_SVH
`define BSC_REGS_SVH
`define BSC_OFF_CTRL 4'h0
`define BSC_OFF_CH1_CNT 4'h1
`define BSC_OFF_CH2_CNT 4'h2
`define BSC_OFF_RESULT1 4'h3
`define BSC_OFF_RESULT2 4'h4
`define BSC_OFF_STATUS 4'h5
`define BSC_OFF_IRQ_STAT 4'h6
`define BSC_OFF_IRQ_MASK 4'h7
`define BSC_OFF_SYS_ERR 4'h8
`define BSC_CTRL_BYTE_MODE 0
`define BSC_CTRL_PROTO_BIDIR1 1
`define BSC_CTRL_PROTO_BIDIR2 2
`define BSC_CTRL_RESET 32'h0000_0007
`define BSC_ERR_NONE 16'h0000
`define BSC_ERR_SIMUL 16'h7FF0
`define BSC_ERR_PROTO 16'h7FF2
`define BSC_ERR_COUNT 16'h7001
`define BSC_ERR_CHAN 16'h4001
`define BSC_CPU_ERR_MAX 16'h4FFF
`define BSC_MOD_ERR_MIN 16'h7000
`define BSC_CH_FIRST 16'h0001
`define BSC_CH_SECOND 16'h0002
`endif

// ---- bsc_pkg.sv ----
// Types shared by the send command block
package bsc_pkg;
  typedef enum logic [3:0] {
    BSC_IDLE = 4'b0001,
    BSC_SEND = 4'b0010,
    BSC_WAIT = 4'b0100,
    BSC_DONE = 4'b1000
  } bsc_state_e;
  typedef struct packed {
    logic [15:0] channel;
    logic [15:0] count;
    logic [15:0] buf_head;
  } bsc_req_s;
  typedef struct packed {
    logic done;
    logic abnormal;
  } bsc_flag_s;
endpackage : bsc_pkg

// ---- bsc_send.sv ----
// Bidirectional send command handler with two channels and Avalon-MM registers
// Operation
// RULE_01 - Channel word 1 or 2 selects transmit channel
// RULE_02 - Result word zero normal, else error code
// RULE_03 - Requester gives count of at least one
// RULE_04 - Count is bytes or words per unit mode
// RULE_05 - Send source buffer data from head location
// RULE_06 - Repeat send on busy channel ignored
// RULE_07 - Later of send/setting/init fails with 7FF0
// RULE_08 - Foreign protocol on channel reports 7FF2
// RULE_09 - Done flag high one scan at end
// RULE_10 - Status flag high one scan if abnormal
// RULE_11 - Store error code; set cpu error flag
// RULE_12 - Codes to 4FFF CPU, from 7000 module
// RULE_13 - Requester addresses module by start number
// RULE_14 - Result written no later than done flag
// RULE_15 - Requester issues only while done low
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
`include "bsc_regs.svh"
module bsc_send #(
  parameter int unsigned NCH = 2,
  parameter logic [7:0] MODULE_START_IO = 8'h00
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] req_start_io,
  input wire logic bidir_send_request,
  input wire bsc_pkg::bsc_req_s req_data,
  input wire logic channel_setting_request,
  input wire logic [15:0] channel_setting_ch,
  input wire logic channel_setting_done,
  input wire logic module_init_request,
  input wire logic module_init_done,
  input wire logic foreign_proto_request,
  input wire logic [15:0] foreign_proto_ch,
  input wire logic scan_end,
  output logic [15:0] buf_rd_addr,
  output logic [NCH-1:0] buf_rd_req,
  input wire logic [15:0] buf_rd_data,
  output logic [NCH-1:0] tx_valid,
  output logic [15:0] tx_data [NCH],
  output logic [NCH-1:0] tx_is_byte,
  input wire logic [NCH-1:0] tx_ready,
  output bsc_pkg::bsc_flag_s [NCH-1:0] flags,
  output logic [15:0] result_word [NCH],
  output logic cpu_error_flag,
  output logic [15:0] cpu_error_code_word,
  output logic irq
);
  logic [31:0] ctrl;
  logic [31:0] irq_stat;
  logic [31:0] irq_mask;
  logic [NCH-1:0] busy;
  logic [NCH-1:0] set_active;
  logic init_active;
  logic [NCH-1:0] grant;
  logic [NCH-1:0] ev_done;
  logic [NCH-1:0] ev_err;
  logic wr_ack;
  logic rd_ack;
  logic ours;

  function automatic logic ch_hit(input logic [15:0] chw, input int unsigned idx);
    ch_hit = (chw == 16'(idx + 1));
  endfunction : ch_hit

  assign ours = (req_start_io == MODULE_START_IO); // RULE_13
  assign irq = |(irq_stat & irq_mask);

  // Grant only one channel per cycle: the bus buffer port is shared
  always_comb begin
    grant = '0;
    for (int i = 0; i < NCH; i++) begin
      if (busy[i] && buf_rd_req[i] && grant == '0) begin
        grant[i] = 1'b1;
      end
    end
  end

  // Conflict trackers for setting and init requests
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      set_active <= '0;
      init_active <= 1'b0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (channel_setting_done) begin
          set_active[i] <= 1'b0;
        end else if (channel_setting_request && ch_hit(channel_setting_ch, i) && !busy[i]) begin
          set_active[i] <= 1'b1; // RULE_07
        end
      end
      if (module_init_done) begin
        init_active <= 1'b0;
      end else if (module_init_request && busy == '0) begin
        init_active <= 1'b1; // RULE_07
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      bsc_pkg::bsc_state_e state;
      logic [15:0] remain;
      logic [15:0] addr;
      logic byte_mode;
      logic hi_half;
      logic [15:0] err;
      logic [15:0] word;
      logic have_word;
      logic start;
      logic proto_ok;

      assign proto_ok = ctrl[`BSC_CTRL_PROTO_BIDIR1 + g];
      assign start = ours && bidir_send_request && ch_hit(req_data.channel, g)
        && state == bsc_pkg::BSC_IDLE; // RULE_01 RULE_06
      assign busy[g] = (state != bsc_pkg::BSC_IDLE);
      assign buf_rd_req[g] = (state == bsc_pkg::BSC_SEND) && !have_word;
      assign tx_valid[g] = (state == bsc_pkg::BSC_SEND) && have_word;
      assign ev_done[g] = (state == bsc_pkg::BSC_DONE) && scan_end;
      assign ev_err[g] = ev_done[g] && (err != `BSC_ERR_NONE);

      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          state <= bsc_pkg::BSC_IDLE;
          remain <= 16'h0000;
          addr <= 16'h0000;
          byte_mode <= 1'b0;
          hi_half <= 1'b0;
          err <= `BSC_ERR_NONE;
          word <= 16'h0000;
          have_word <= 1'b0;
          result_word[g] <= 16'h0000;
        end else begin
          unique case (state)
            bsc_pkg::BSC_IDLE: begin
              if (start) begin
                remain <= req_data.count; // RULE_03
                addr <= req_data.buf_head; // RULE_05
                byte_mode <= ctrl[`BSC_CTRL_BYTE_MODE]; // RULE_04
                hi_half <= 1'b0;
                have_word <= 1'b0;
                if (!proto_ok || (foreign_proto_request && ch_hit(foreign_proto_ch, g))) begin
                  err <= `BSC_ERR_PROTO; // RULE_08
                  state <= bsc_pkg::BSC_WAIT;
                end else if (set_active[g] || init_active) begin
                  err <= `BSC_ERR_SIMUL; // RULE_07
                  state <= bsc_pkg::BSC_WAIT;
                end else if (req_data.count == 16'h0000) begin
                  err <= `BSC_ERR_COUNT; // RULE_12
                  state <= bsc_pkg::BSC_WAIT;
                end else begin
                  err <= `BSC_ERR_NONE;
                  state <= bsc_pkg::BSC_SEND;
                end
              end
            end
            bsc_pkg::BSC_SEND: begin
              // Setting or init arriving now is the later request: it fails, the send goes on
              if (foreign_proto_request && ch_hit(foreign_proto_ch, g)) begin
                err <= `BSC_ERR_PROTO; // RULE_08
                state <= bsc_pkg::BSC_WAIT;
              end else if (grant[g]) begin
                word <= buf_rd_data; // RULE_05
                have_word <= 1'b1;
                addr <= addr + 16'h0001;
              end else if (have_word && tx_ready[g]) begin
                // Byte mode sends low then high byte of each word; an odd count ends on a low byte alone
                if (byte_mode && !hi_half && remain != 16'h0001) begin
                  hi_half <= 1'b1; // RULE_04
                end else begin
                  hi_half <= 1'b0;
                  have_word <= 1'b0;
                end
                remain <= remain - 16'h0001;
                if (remain == 16'h0001) begin
                  state <= bsc_pkg::BSC_WAIT;
                end
              end
            end
            bsc_pkg::BSC_WAIT: begin
              result_word[g] <= err; // RULE_02 RULE_11 RULE_14
              state <= bsc_pkg::BSC_DONE;
            end
            bsc_pkg::BSC_DONE: begin
              if (scan_end) begin
                state <= bsc_pkg::BSC_IDLE;
              end
            end
            default: begin
              state <= bsc_pkg::BSC_IDLE;
            end
          endcase
        end
      end

      // Flags held for one scan, from the end of scan that sees completion
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          flags[g] <= '0;
        end else if (ev_done[g]) begin
          flags[g].done <= 1'b1; // RULE_09
          flags[g].abnormal <= (err != `BSC_ERR_NONE); // RULE_10
        end else if (scan_end) begin
          flags[g] <= '0; // RULE_09 RULE_10
        end
      end

      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          tx_data[g] <= 16'h0000;
          tx_is_byte[g] <= 1'b0;
        end else begin
          tx_is_byte[g] <= byte_mode;
          tx_data[g] <= !byte_mode ? word :
            (hi_half ? {8'h00, word[15:8]} : {8'h00, word[7:0]});
        end
      end
    end
  endgenerate

  always_comb begin
    buf_rd_addr = 16'h0000;
    for (int i = 0; i < NCH; i++) begin
      if (grant[i]) begin
        buf_rd_addr = g_addr_sel(i);
      end
    end
  end

  function automatic logic [15:0] g_addr_sel(input int unsigned idx);
    g_addr_sel = (idx == 0) ? g_ch[0].addr : g_ch[NCH-1].addr;
  endfunction : g_addr_sel

  // CPU-side error: a send addressed here with a channel outside 1..2
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_error_flag <= 1'b0;
      cpu_error_code_word <= 16'h0000;
    end else if (ours && bidir_send_request
        && req_data.channel != `BSC_CH_FIRST && req_data.channel != `BSC_CH_SECOND) begin
      cpu_error_flag <= 1'b1; // RULE_11
      cpu_error_code_word <= `BSC_ERR_CHAN; // RULE_12
    end else if (wr_ack && avs_address == `BSC_OFF_SYS_ERR) begin
      cpu_error_flag <= 1'b0;
    end
  end

  // Sticky interrupt bits; set wins over write-one-to-clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < 32; i++) begin
        if (i < NCH && ev_done[i % NCH]) begin
          irq_stat[i] <= 1'b1;
        end else if (i >= 8 && i < 8 + NCH && ev_err[(i - 8) % NCH]) begin
          irq_stat[i] <= 1'b1;
        end else if (wr_ack && avs_address == `BSC_OFF_IRQ_STAT && avs_writedata[i]) begin
          irq_stat[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= `BSC_CTRL_RESET;
      irq_mask <= 32'h0000_0000;
    end else if (wr_ack) begin
      if (avs_address == `BSC_OFF_CTRL) begin
        ctrl <= avs_writedata & 32'h0000_0007;
      end
      if (avs_address == `BSC_OFF_IRQ_MASK) begin
        irq_mask <= avs_writedata & 32'h0000_0303;
      end
    end
  end

  // One wait cycle per read, none per write, so read data comes from a flop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_ack <= avs_read && !rd_ack;
      if (avs_read && !rd_ack) begin
        unique case (avs_address)
          `BSC_OFF_CTRL: avs_readdata <= ctrl;
          `BSC_OFF_RESULT1: avs_readdata <= {16'h0000, result_word[0]};
          `BSC_OFF_RESULT2: avs_readdata <= {16'h0000, result_word[NCH-1]};
          `BSC_OFF_STATUS: avs_readdata <= {24'h000000, 6'h00, busy};
          `BSC_OFF_IRQ_STAT: avs_readdata <= irq_stat;
          `BSC_OFF_IRQ_MASK: avs_readdata <= irq_mask;
          `BSC_OFF_SYS_ERR: avs_readdata <= {15'h0000, cpu_error_flag, cpu_error_code_word};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wr_ack = avs_write;
  assign avs_waitrequest = avs_read && !rd_ack;
endmodule : bsc_send

// ---- bsc_far_model.sv ----
// Far-side model: source buffer memory and transmit sink
`timescale 1ns/100ps
module bsc_far_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic slow,
  input wire logic [15:0] buf_rd_addr,
  input wire logic [1:0] buf_rd_req,
  output logic [15:0] buf_rd_data,
  input wire logic [1:0] tx_valid,
  output logic [1:0] tx_ready
);
  logic [1:0] held;
  logic [1:0] pace;
  logic [15:0] last;
  // Released bus toggles, so a stale word never looks valid
  assign buf_rd_data = (|buf_rd_req) ? (buf_rd_addr ^ 16'h3C5A) : ~last;
  // Ready only once valid has stood a cycle, since tx_data lags
  assign tx_ready = tx_valid & held & {2{!slow || pace == 2'h3}};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      held <= 2'h0;
      pace <= 2'h0;
      last <= 16'h0000;
    end else begin
      held <= tx_valid & ~tx_ready;
      pace <= pace + 2'h1;
      last <= buf_rd_data;
    end
  end
endmodule : bsc_far_model

// ---- bsc_send_checker.sv ----
// Concurrent checks on the send command block outputs
`timescale 1ns/100ps
module bsc_send_checker #(
  parameter int unsigned NCH = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scan_end,
  input wire logic [NCH-1:0] tx_valid,
  input wire logic [NCH-1:0] tx_ready,
  input wire bsc_pkg::bsc_flag_s [NCH-1:0] flags,
  input wire logic [15:0] result_word [NCH],
  input wire logic cpu_error_flag,
  input wire logic [15:0] cpu_error_code_word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_done_end;
    flags[0].done && scan_end;
  endsequence
  sequence s_abn_end;
    flags[1].abnormal && scan_end;
  endsequence
  chk_done_at_scan: assert property ($rose(flags[0].done) |-> $past(scan_end))
    else $error("done rose off scan end");
  chk_done_one_scan: assert property (s_done_end |=> !flags[0].done)
    else $error("done held past one scan");
  chk_abn_with_done: assert property (flags[0].abnormal |-> flags[0].done)
    else $error("abnormal without done");
  chk_abn_one_scan: assert property (s_abn_end |=> !flags[1].abnormal)
    else $error("abnormal held past one scan");
  chk_normal_zero: assert property ($rose(flags[0].done) && !flags[0].abnormal |->
    result_word[0] == 16'h0000)
    else $error("normal finish with nonzero result");
  chk_error_code: assert property ($rose(flags[1].abnormal) |-> result_word[1] != 16'h0000)
    else $error("abnormal finish with zero result");
  chk_result_first: assert property ($rose(flags[0].done) |-> $stable(result_word[0]))
    else $error("result changed with done");
  chk_cpu_code: assert property (cpu_error_flag |->
    cpu_error_code_word inside {[16'h0001:16'h4FFF]})
    else $error("cpu error code out of range");
  chk_tx_hold: assert property (tx_valid[0] && !tx_ready[0] |=> tx_valid[0])
    else $error("unit dropped before ready");
endmodule : bsc_send_checker
bind bsc_send bsc_send_checker #(.NCH(NCH)) u_chk (
  .clk(clk), .arst_n(arst_n), .scan_end(scan_end), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .flags(flags), .result_word(result_word),
  .cpu_error_flag(cpu_error_flag), .cpu_error_code_word(cpu_error_code_word)
);

// ---- testbench.sv ----
// Self-checking bench for the send command block
`timescale 1ns/100ps
module testbench;
  logic clk = 0, arst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [3:0] avs_address = 0, sc = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, rd;
  logic slow = 0, bmode = 1, ia, cpu_error_flag, irq, scan_end = 0;
  logic [7:0] req_start_io = 0;
  logic bidir_send_request = 0, channel_setting_request = 0, channel_setting_done = 0;
  logic module_init_request = 0, module_init_done = 0, foreign_proto_request = 0;
  logic [15:0] foreign_proto_ch = 0;
  bsc_pkg::bsc_req_s req_data = '0;
  logic [15:0] channel_setting_ch = 0, buf_rd_addr, buf_rd_data, cpu_error_code_word, hd, cn;
  logic [15:0] tx_data [2];
  logic [15:0] result_word [2];
  logic [15:0] q [2][$];
  logic [15:0] e [2][$];
  logic [1:0] buf_rd_req, tx_valid, tx_is_byte, tx_ready;
  bsc_pkg::bsc_flag_s [1:0] flags;
  int err_total = 0, compares = 0;
  integer seed = 32'hcfd379f9;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    sc <= sc + 4'h1;
    scan_end <= (sc == 4'hF);
  end
  always @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (tx_valid[i] && tx_ready[i]) begin
        q[i].push_back(tx_data[i]);
        chk("is_byte", tx_is_byte[i], bmode);
      end
    end
  end
  bsc_send u_dut (.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .req_start_io(req_start_io),
    .bidir_send_request(bidir_send_request), .req_data(req_data),
    .channel_setting_request(channel_setting_request), .channel_setting_ch(channel_setting_ch),
    .channel_setting_done(channel_setting_done), .module_init_request(module_init_request),
    .module_init_done(module_init_done), .foreign_proto_request(foreign_proto_request),
    .foreign_proto_ch(foreign_proto_ch), .scan_end(scan_end), .buf_rd_addr(buf_rd_addr),
    .buf_rd_req(buf_rd_req), .buf_rd_data(buf_rd_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_is_byte(tx_is_byte), .tx_ready(tx_ready), .flags(flags), .result_word(result_word),
    .cpu_error_flag(cpu_error_flag), .cpu_error_code_word(cpu_error_code_word), .irq(irq));
  bsc_far_model u_far (.clk(clk), .arst_n(arst_n), .slow(slow), .buf_rd_addr(buf_rd_addr),
    .buf_rd_req(buf_rd_req), .buf_rd_data(buf_rd_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic req(input logic [15:0] ch, input logic [15:0] n, input logic [15:0] h,
    input bit push);
    logic [15:0] w;
    bidir_send_request <= 1'b1;
    req_data <= '{ch, n, h};
    @(posedge clk);
    bidir_send_request <= 1'b0;
    @(posedge clk);
    if (push) for (int k = 0; k < n; k++) begin
      w = (h + (bmode ? k / 2 : k)) ^ 16'h3C5A;
      e[ch-1].push_back(!bmode ? w : (k % 2 ? {8'h00, w[15:8]} : {8'h00, w[7:0]}));
    end
  endtask : req
  task automatic fin(input int c, input logic [15:0] code);
    do @(posedge clk); while (flags[c].done !== 1'b1);
    chk("result", result_word[c], code);
    chk("abnormal", flags[c].abnormal, code != 16'h0000);
    chk("units", q[c].size(), e[c].size());
    while (q[c].size() && e[c].size()) begin
      chk("unit", q[c].pop_front() & (bmode ? 16'h00FF : 16'hFFFF), e[c].pop_front());
    end
    q[c].delete();
    e[c].delete();
    do @(posedge clk); while (flags[c].done !== 1'b0);
  endtask : fin
  task automatic close_out;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    bus(0, 4'h0, 0);
    chk("ctrl", rd, 32'h0000_0007);
    bus(0, 4'hF, 0);
    chk("unmapped", rd, 32'h0000_0000);
    bus(1, 4'h6, 32'hFFFF_FFFF);
    repeat (3) begin
      hd = $random(seed);
      cn = ($random(seed) & 3) + 1;
      req(1, cn, hd, 1);
      fin(0, 16'h0000);
    end
    chk("idle_ch", q[1].size(), 0);
    bus(0, 4'h6, 0);
    chk("irq_stat", rd, 32'h0000_0001);
    bus(1, 4'h7, 0);
    ia = irq;
    bus(1, 4'h7, 32'hFFFF_FFFF);
    chk("irq_mask", ia ^ irq, 1);
    bus(1, 4'h6, 32'h0000_0001);
    bus(0, 4'h6, 0);
    chk("irq_clear", {rd[0], irq}, 0);
    $display("test byte_irq done");
    req(2, 0, 0, 0);
    fin(1, 16'h7001);
    bus(1, 4'h0, 32'h0000_0006);
    bmode = 0;
    slow <= 1'b1;
    req(1, 4, hd, 1);
    req(1, 2, 16'h0100, 0);
    req(2, 3, ~hd, 1);
    fork fin(0, 16'h0000); fin(1, 16'h0000); join
    slow <= 1'b0;
    $display("test word_parallel done");
    bus(1, 4'h0, 32'h0000_0005);
    bmode = 1;
    req(1, 2, 0, 0);
    fin(0, 16'h7FF2);
    bus(1, 4'h0, 32'h0000_0007);
    for (int k = 0; k < 2; k++) begin
      channel_setting_request <= (k == 0);
      module_init_request <= (k == 1);
      channel_setting_ch <= 16'h0001;
      @(posedge clk);
      channel_setting_request <= 1'b0;
      module_init_request <= 1'b0;
      req(k + 1, 2, 0, 0);
      fin(k, 16'h7FF0);
      channel_setting_done <= (k == 0);
      module_init_done <= (k == 1);
      @(posedge clk);
      channel_setting_done <= 1'b0;
      module_init_done <= 1'b0;
    end
    $display("test conflicts done");
    for (int k = 0; k < 2; k++) begin
      req(2, 2, hd, k == 0);
      channel_setting_request <= (k == 0);
      module_init_request <= (k == 0);
      channel_setting_ch <= 16'h0002;
      foreign_proto_request <= (k == 1);
      foreign_proto_ch <= 16'h0002;
      @(posedge clk);
      channel_setting_request <= 1'b0;
      module_init_request <= 1'b0;
      foreign_proto_request <= 1'b0;
      fin(1, k ? 16'h7FF2 : 16'h0000);
    end
    $display("test mid_send done");
    req(3, 1, 0, 0);
    bus(0, 4'h8, 0);
    chk("sys_err", rd, 32'h0001_4001);
    chk("cpu_err", {cpu_error_flag, cpu_error_code_word}, 32'h0001_4001);
    bus(1, 4'h8, 0);
    chk("cpu_clear", cpu_error_flag, 0);
    req_start_io <= 8'h01;
    req(1, 2, 0, 0);
    repeat (40) @(posedge clk);
    chk("ignored", q[0].size() | flags[0].done, 0);
    $display("test errors done");
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out;
  end
endmodule : testbench
